// [src/parallel_port_cfg.svh]
// Constants for the parallel port: mode codes, pin bit positions, reset values and cycle figures.
`ifndef PARALLEL_PORT_CFG_SVH
`define PARALLEL_PORT_CFG_SVH
// ==========================================================================
// Mode and multiplexing codes
`define PP_MODE_LEGACY 2'h0
`define PP_MUX_FULL8 2'h2
`define PP_MUX_FULL16 2'h3
// ==========================================================================
// Field positions and sizes
`define PP_DATA_W 16
`define PP_FIFO_DEPTH 16
`define PP_CS1_ADDR_BIT 14
`define PP_CS2_ADDR_BIT 15
// Cycles of each address latch phase besides its begin wait: one drive, one hold.
`define PP_LATCH_FIXED 6'h02
// ==========================================================================
// Reset values
`define PP_RX_RESET 16'h0000
// ==========================================================================
// Whole master cycle lengths in clock cycles for the reference settings
`define PP_CYC_W8_NOWAIT 6'h09
`define PP_CYC_W8_WAIT 6'h0F
`define PP_CYC_R16_NOWAIT 6'h05
`define PP_CYC_R16_WAIT 6'h0A
`define PP_CYC_W16_NOWAIT 6'h06
`define PP_CYC_W16_WAIT 6'h0B
`endif

// [src/parallel_port_pkg.sv]
// Types shared by the parallel port design.
package parallel_port_pkg;
  // ==========================================================================
  // Master bus sequencer states, Gray coded along the cycle.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_BEGIN = 3'h3,
    ST_MID   = 3'h2,
    ST_END   = 3'h6
  } bus_state_t;

  // ==========================================================================
  // Everything one master cycle needs, caught when the cycle starts.
  typedef struct packed {
    logic is_write;
    logic is8;
    logic [2:0] b_len;
    logic [4:0] m_len;
    logic [2:0] e_len;
    logic cs1;
    logic cs2;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cycle_t;

  // Slave control pins as seen from outside.
  typedef struct packed {
    logic cs1;
    logic wr;
    logic rd;
  } slave_pins_t;
endpackage

// [src/parallel_port_mux_slave.sv]
// Parallel port: multiplexed master bus sequencer, legacy slave write path and write request FIFO.
`include "parallel_port_cfg.svh"

// ==========================================================================
// Write request FIFO
module byte_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable.
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Filling side.
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side.
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap by width, so only powers of two are served.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // Handshakes and the next fill level.
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign o_out_data = mem[rptr];

  // Pointers and flags; full and empty are registered so they never glitch.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else if (i_ce) begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      count <= next_count;
      o_in_ready <= next_count != (AW+1)'(DEPTH);
      o_out_valid <= next_count != '0;
    end
  end

  // Storage is not reset; nothing reads an entry before it is written.
  always_ff @(posedge i_clk) begin
    if (i_ce && push) mem[wptr] <= i_in_data;
  end
endmodule

// ==========================================================================
// Top level
module parallel_port_mux_slave #(
  parameter int FIFO_DEPTH = `PP_FIFO_DEPTH
) (
  // Clock, reset, enable.
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Configuration.
  input wire logic i_enable,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_addr_data_mux_select,
  input wire logic [1:0] i_begin_phase_wait,
  input wire logic [3:0] i_middle_phase_wait,
  input wire logic [1:0] i_end_phase_wait,
  input wire logic i_read_strobe_polarity,
  input wire logic i_write_strobe_polarity,
  input wire logic i_chip_select_one_polarity,
  input wire logic i_cs1_enable,
  input wire logic i_cs2_enable,
  input wire logic [15:0] i_port_address_reg,
  // Software access to the write FIFO, receive register and status.
  input wire logic i_rx_read,
  input wire logic i_tx_valid,
  input wire logic [15:0] i_tx_data,
  input wire logic i_irq_clear,
  input wire logic i_overflow_clear,
  output logic o_tx_ready,
  output logic [15:0] o_rx_data,
  output logic o_busy,
  output logic o_input_buffer_full_flag,
  output logic o_input_overflow_flag,
  output logic o_port_irq_flag,
  // Data lines.
  input wire logic [15:0] i_port_data_lines,
  output logic [15:0] o_port_data_lines,
  output logic o_port_data_oe,
  // Strobes and chip selects.
  input wire logic i_port_read_strobe,
  input wire logic i_port_write_strobe,
  input wire logic i_port_chip_select_one,
  output logic o_port_read_strobe,
  output logic o_port_write_strobe,
  output logic o_port_chip_select_one,
  output logic o_port_chip_select_two,
  output logic o_port_ctrl_oe,
  output logic o_addr_latch_low,
  output logic o_addr_latch_high
);
  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("FIFO_DEPTH must be at least 2");
  end

  parallel_port_pkg::bus_state_t state;
  parallel_port_pkg::cycle_t tp;
  parallel_port_pkg::cycle_t next_tp;
  parallel_port_pkg::slave_pins_t s1;
  parallel_port_pkg::slave_pins_t s2;
  parallel_port_pkg::slave_pins_t s3;
  logic [4:0] pc;
  logic lat_second;
  logic [5:0] rem;
  logic [5:0] next_total;
  logic [5:0] lat_len;
  logic [5:0] meas;
  logic [7:0] d1;
  logic [7:0] d2;
  logic master_on;
  logic slave_on;
  logic start_rd;
  logic start_wr;
  logic start;
  logic sm_last;
  logic cap_pending;
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic forced;
  logic wr_act2;
  logic wr_act3;
  logic rd_act2;
  logic rd_act3;
  logic cs_act2;
  logic wr_edge;
  logic rd_edge;
  logic rx_clear;
  logic accept;
  logic latch_on;
  logic mwr_act;

  // Mode 00 is the legacy slave; any other mode runs the master sequencer.
  assign slave_on = i_enable && i_mode == `PP_MODE_LEGACY;
  assign master_on = i_enable && i_mode != `PP_MODE_LEGACY;
  assign start_rd = master_on && state == parallel_port_pkg::ST_IDLE && i_rx_read;
  assign start_wr = master_on && state == parallel_port_pkg::ST_IDLE && !i_rx_read && fifo_valid;
  assign start = start_rd | start_wr;

  // Pending software writes queue here and drain one per master write cycle.
  byte_fifo #(.WIDTH(`PP_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_data),
    .o_in_ready(o_tx_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(start_wr)
  );

  // Phase lengths of the cycle about to start; a zero middle code forces the others.
  always_comb begin
    forced = i_middle_phase_wait == 4'h0;
    next_tp.is_write = !i_rx_read;
    next_tp.is8 = i_addr_data_mux_select == `PP_MUX_FULL8;
    next_tp.b_len = forced ? 3'h1 : {1'b0, i_begin_phase_wait} + 3'h1;
    next_tp.m_len = {1'b0, i_middle_phase_wait} + 5'h01;
    if (next_tp.is_write) begin
      next_tp.e_len = forced ? 3'h1 : {1'b0, i_end_phase_wait} + 3'h1;
    end else begin
      next_tp.e_len = forced ? 3'h0 : {1'b0, i_end_phase_wait};
    end
    next_tp.cs1 = i_cs1_enable & i_port_address_reg[`PP_CS1_ADDR_BIT];
    next_tp.cs2 = i_cs2_enable & i_port_address_reg[`PP_CS2_ADDR_BIT];
    next_tp.addr = i_port_address_reg;
    if (i_cs1_enable) next_tp.addr[`PP_CS1_ADDR_BIT] = 1'b0;
    if (i_cs2_enable) next_tp.addr[`PP_CS2_ADDR_BIT] = 1'b0;
    next_tp.wdata = fifo_data;
    lat_len = {3'h0, next_tp.b_len} + `PP_LATCH_FIXED;
    next_total = (next_tp.is8 ? lat_len + lat_len : lat_len) + {3'h0, next_tp.b_len}
      + {1'b0, next_tp.m_len} + {3'h0, next_tp.e_len};
  end

  // The sequencer ends on the last middle cycle of a read without end phase, else on the last end cycle.
  assign sm_last = (state == parallel_port_pkg::ST_MID && pc == 5'h00 && tp.e_len == 3'h0)
    || (state == parallel_port_pkg::ST_END && pc == 5'h00);

  // Master sequencer; disabling or entering slave mode aborts a cycle in flight.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= parallel_port_pkg::ST_IDLE;
      tp <= '0;
      pc <= 5'h00;
      lat_second <= 1'b0;
    end else if (i_ce) begin
      pc <= pc - 5'h01;
      if (!master_on) begin
        state <= parallel_port_pkg::ST_IDLE;
      end else begin
        case (state)
          parallel_port_pkg::ST_IDLE: begin
            if (start) begin
              state <= parallel_port_pkg::ST_ADDR;
              tp <= next_tp;
              pc <= {2'h0, next_tp.b_len} + 5'h01;
              lat_second <= 1'b0;
            end
          end
          parallel_port_pkg::ST_ADDR: begin
            if (pc == 5'h00) begin
              if (tp.is8 && !lat_second) begin
                pc <= {2'h0, tp.b_len} + 5'h01;
                lat_second <= 1'b1;
              end else begin
                state <= parallel_port_pkg::ST_BEGIN;
                pc <= {2'h0, tp.b_len} - 5'h01;
              end
            end
          end
          parallel_port_pkg::ST_BEGIN: begin
            if (pc == 5'h00) begin
              state <= parallel_port_pkg::ST_MID;
              pc <= tp.m_len - 5'h01;
            end
          end
          parallel_port_pkg::ST_MID: begin
            if (pc == 5'h00) begin
              if (tp.e_len == 3'h0) begin
                state <= parallel_port_pkg::ST_IDLE;
              end else begin
                state <= parallel_port_pkg::ST_END;
                pc <= {2'h0, tp.e_len} - 5'h01;
              end
            end
          end
          parallel_port_pkg::ST_END: begin
            if (pc == 5'h00) state <= parallel_port_pkg::ST_IDLE;
          end
          default: state <= parallel_port_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Busy counts down the whole cycle and falls as the last cycle begins.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rem <= 6'h00;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      if (!master_on) begin
        rem <= 6'h00;
        o_busy <= 1'b0;
      end else if (start) begin
        rem <= next_total - 6'h01;
        o_busy <= 1'b1;
      end else if (state != parallel_port_pkg::ST_IDLE) begin
        rem <= rem - 6'h01;
        o_busy <= rem > 6'h01;
      end
    end
  end

  // Pins follow the sequencer one cycle later, so every output leaves a flop.
  assign latch_on = state == parallel_port_pkg::ST_ADDR && pc != 5'h00 && pc <= {2'h0, tp.b_len};
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_port_data_lines <= 16'h0000;
      o_port_data_oe <= 1'b0;
      o_port_read_strobe <= 1'b0;
      o_port_write_strobe <= 1'b0;
      o_port_chip_select_one <= 1'b0;
      o_port_chip_select_two <= 1'b0;
      o_port_ctrl_oe <= 1'b0;
      o_addr_latch_low <= 1'b0;
      o_addr_latch_high <= 1'b0;
      cap_pending <= 1'b0;
    end else if (i_ce) begin
      if (state == parallel_port_pkg::ST_ADDR) begin
        if (!tp.is8) o_port_data_lines <= tp.addr;
        else if (lat_second) o_port_data_lines <= {8'h00, tp.addr[15:8]};
        else o_port_data_lines <= {8'h00, tp.addr[7:0]};
      end else if (state != parallel_port_pkg::ST_IDLE) begin
        o_port_data_lines <= tp.is8 ? {8'h00, tp.wdata[7:0]} : tp.wdata;
      end
      // The end phase keeps the selects, and for a write the data, on the bus after the strobe.
      o_port_data_oe <= master_on && (state == parallel_port_pkg::ST_ADDR
        || (tp.is_write && state != parallel_port_pkg::ST_IDLE));
      o_port_read_strobe <= ~((state == parallel_port_pkg::ST_MID && !tp.is_write) ^ i_read_strobe_polarity);
      o_port_write_strobe <= ~((state == parallel_port_pkg::ST_MID && tp.is_write) ^ i_write_strobe_polarity);
      o_port_chip_select_one <= ~((state != parallel_port_pkg::ST_IDLE && tp.cs1) ^ i_chip_select_one_polarity);
      o_port_chip_select_two <= state != parallel_port_pkg::ST_IDLE && tp.cs2;
      o_port_ctrl_oe <= master_on;
      o_addr_latch_low <= latch_on && !lat_second;
      o_addr_latch_high <= latch_on && (lat_second || !tp.is8);
      cap_pending <= master_on && state == parallel_port_pkg::ST_MID && pc == 5'h00 && !tp.is_write;
    end
  end

  // Slave pins cross into this clock through two flops; the third only feeds edge detection.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      d1 <= 8'h00;
      d2 <= 8'h00;
    end else if (i_ce) begin
      s1 <= {i_port_chip_select_one, i_port_write_strobe, i_port_read_strobe};
      s2 <= s1;
      s3 <= s2;
      d1 <= i_port_data_lines[7:0];
      d2 <= d1;
    end
  end

  // Polarity bit 1 means the pin is active high.
  assign wr_act2 = s2.wr ~^ i_write_strobe_polarity;
  assign wr_act3 = s3.wr ~^ i_write_strobe_polarity;
  assign rd_act2 = s2.rd ~^ i_read_strobe_polarity;
  assign rd_act3 = s3.rd ~^ i_read_strobe_polarity;
  assign cs_act2 = s2.cs1 ~^ i_chip_select_one_polarity;
  assign wr_edge = slave_on && cs_act2 && wr_act2 && !wr_act3;
  assign rd_edge = slave_on && cs_act2 && rd_act2 && !rd_act3;
  assign rx_clear = slave_on && i_rx_read;
  // A read in the same cycle frees the buffer, so the arriving byte is kept.
  assign accept = wr_edge && (!o_input_buffer_full_flag || rx_clear);

  // Receive register: master read data or slave byte.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_data <= `PP_RX_RESET;
    end else if (i_ce) begin
      if (cap_pending) begin
        o_rx_data <= tp.is8 ? {o_rx_data[15:8], i_port_data_lines[7:0]} : i_port_data_lines;
      end else if (accept) begin
        o_rx_data[7:0] <= d2;
      end
    end
  end

  // Status flags; a new event beats a clear in the same cycle.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_input_buffer_full_flag <= 1'b0;
      o_input_overflow_flag <= 1'b0;
      o_port_irq_flag <= 1'b0;
    end else if (i_ce) begin
      if (accept) o_input_buffer_full_flag <= 1'b1;
      else if (rx_clear) o_input_buffer_full_flag <= 1'b0;
      if (wr_edge && !accept) o_input_overflow_flag <= 1'b1;
      else if (i_overflow_clear) o_input_overflow_flag <= 1'b0;
      if (wr_edge || rd_edge) o_port_irq_flag <= 1'b1;
      else if (i_irq_clear) o_port_irq_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) meas <= 6'h00;
    else if (i_ce) meas <= start ? 6'h01 : meas + 6'h01;
  end
  assign mwr_act = o_port_write_strobe ~^ i_write_strobe_polarity;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst || !i_ce);

  a_mux_code: assert property (start && i_addr_data_mux_select == 2'h2 |=> tp.is8)
    else $error("mux code 10 did not select 8-bit");
  a_start_read: assert property (start_rd |=> state == parallel_port_pkg::ST_ADDR ##1 o_busy)
    else $error("receive read did not start a cycle");
  a_busy_early: assert property (sm_last |-> !o_busy && $past(o_busy) ##1 state == parallel_port_pkg::ST_IDLE)
    else $error("busy not dropped exactly one cycle before end");
  a_len_w8_plain: assert property (sm_last && tp.is_write && tp.is8 && tp.b_len == 3'h1 && tp.m_len == 5'h01
    && tp.e_len == 3'h1 |-> meas == `PP_CYC_W8_NOWAIT)
    else $error("8-bit write length wrong");
  a_len_w8_wait: assert property (sm_last && tp.is_write && tp.is8 && tp.b_len == 3'h2 && tp.m_len == 5'h03
    && tp.e_len == 3'h2 |-> meas == `PP_CYC_W8_WAIT)
    else $error("8-bit waited write length wrong");
  a_len_r16_plain: assert property (sm_last && !tp.is_write && !tp.is8 && tp.b_len == 3'h1 && tp.m_len == 5'h01
    && tp.e_len == 3'h0 |-> meas == `PP_CYC_R16_NOWAIT)
    else $error("16-bit read length wrong");
  a_len_r16_wait: assert property (sm_last && !tp.is_write && !tp.is8 && tp.b_len == 3'h2 && tp.m_len == 5'h03
    && tp.e_len == 3'h1 |-> meas == `PP_CYC_R16_WAIT)
    else $error("16-bit waited read length wrong");
  a_len_w16_plain: assert property (sm_last && tp.is_write && !tp.is8 && tp.b_len == 3'h1 && tp.m_len == 5'h01
    && tp.e_len == 3'h1 |-> meas == `PP_CYC_W16_NOWAIT)
    else $error("16-bit write length wrong");
  a_len_w16_wait: assert property (sm_last && tp.is_write && !tp.is8 && tp.b_len == 3'h2 && tp.m_len == 5'h03
    && tp.e_len == 3'h2 |-> meas == `PP_CYC_W16_WAIT)
    else $error("16-bit waited write length wrong");
  a_wait_codes: assert property (start && i_middle_phase_wait == 4'h2 && i_begin_phase_wait == 2'h1
    |=> tp.m_len == 5'h03 && tp.b_len == 3'h2)
    else $error("wait codes mapped wrong");
  a_read_forced: assert property (start_rd && i_middle_phase_wait == 4'h0
    |=> tp.b_len == 3'h1 && tp.e_len == 3'h0 && tp.m_len == 5'h01)
    else $error("read phases not forced");
  a_write_forced: assert property (start_wr && i_middle_phase_wait == 4'h0
    |=> tp.b_len == 3'h1 && tp.e_len == 3'h1 && tp.m_len == 5'h01)
    else $error("write phases not forced");
  a_write_hold: assert property (master_on && $fell(mwr_act) |-> o_port_data_oe && $stable(o_port_data_lines))
    else $error("write hold cycle missing");
  a_cs_bit_zero: assert property (o_addr_latch_low && !tp.is8 && i_cs1_enable |-> !o_port_data_lines[14])
    else $error("chip-select address bit not zero");
  a_upper_idle: assert property (tp.is8 && o_port_data_oe |-> o_port_data_lines[15:8] == 8'h00)
    else $error("upper data lines used in 8-bit mode");
  a_slave_pins_in: assert property (slave_on && $past(slave_on) |-> !o_port_ctrl_oe && !o_port_data_oe)
    else $error("slave mode drives control pins");
  a_slave_capture: assert property (wr_edge && !o_input_buffer_full_flag
    |=> o_rx_data[7:0] == $past(d2) && o_input_buffer_full_flag)
    else $error("slave byte not captured");
  a_full_latency: assert property ($rose(o_input_buffer_full_flag)
    |-> $past(i_port_write_strobe, 3) ~^ i_write_strobe_polarity)
    else $error("full flag latency wrong");
  a_full_clear: assert property (rx_clear && !wr_edge |=> !o_input_buffer_full_flag)
    else $error("full flag not cleared by read");
  a_overflow: assert property (wr_edge && o_input_buffer_full_flag && !rx_clear
    |=> o_input_overflow_flag && $stable(o_rx_data))
    else $error("overflow not flagged or byte not dropped");

  c_write8: cover property (sm_last && tp.is_write && tp.is8);
  c_read16_wait: cover property (sm_last && !tp.is_write && !tp.is8 && tp.m_len == 5'h03);
  c_slave_overflow: cover property (wr_edge && o_input_buffer_full_flag);
  c_fifo_full: cover property (!o_tx_ready);
endmodule

// [sim/ext_host.sv]
// External processor model that writes bytes into the slave port.
module ext_host (
  // Clock and pin polarity.
  input wire logic i_clk,
  input wire logic i_pol,
  // Pins driven towards the port.
  output logic [15:0] o_data,
  output logic o_wr,
  output logic o_cs1,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_on = 1'b0;
  logic cs_on = 1'b0;
  // Active level follows the polarity bit; reads are never issued.
  assign o_wr = wr_on ~^ i_pol;
  assign o_cs1 = cs_on ~^ i_pol;
  assign o_rd = ~i_pol;
  initial o_data = 16'h0000;
  // Select the port, present the byte, then raise the strobe.
  task automatic put(input logic [7:0] b);
    o_data = {~b, b};
    cs_on = 1'b1;
    @(negedge i_clk);
    wr_on = 1'b1;
  endtask
  // Released lines show the inverse so stale data is never mistaken for new.
  task automatic rel;
    wr_on = 1'b0;
    @(negedge i_clk);
    cs_on = 1'b0;
    o_data = ~o_data;
    repeat (3) @(negedge i_clk);
  endtask
endmodule

// [sim/tb_parallel_port_mux_slave.sv]
// Self-checking bench for master cycle lengths and the slave write path.
module tb_parallel_port_mux_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, en, rd, txv, irqc, ovc, pol, busy, full, ovf, irq, doe, coe, hw, hc, hr;
  logic ws, alh, cs1o, cs2o;
  logic [1:0] mode, mux, wb, we;
  logic [3:0] wm;
  logic [15:0] txd, rx, hd, pd, pin;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  // Shared data wire: the port wins while it drives.
  assign pin = doe ? pd : hd;
  ext_host host (.i_clk(clk), .i_pol(pol), .o_data(hd), .o_wr(hw), .o_cs1(hc), .o_rd(hr));
  parallel_port_mux_slave DUT (.i_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_enable(en),
    .i_mode(mode), .i_addr_data_mux_select(mux), .i_begin_phase_wait(wb), .i_middle_phase_wait(wm),
    .i_end_phase_wait(we), .i_read_strobe_polarity(pol), .i_write_strobe_polarity(pol),
    .i_chip_select_one_polarity(pol), .i_cs1_enable(1'b1), .i_cs2_enable(1'b1),
    .i_port_address_reg(16'hC1A5), .i_rx_read(rd), .i_tx_valid(txv), .i_tx_data(txd),
    .i_irq_clear(irqc), .i_overflow_clear(ovc), .o_tx_ready(), .o_rx_data(rx), .o_busy(busy),
    .o_input_buffer_full_flag(full), .o_input_overflow_flag(ovf), .o_port_irq_flag(irq),
    .i_port_data_lines(pin), .o_port_data_lines(pd), .o_port_data_oe(doe),
    .i_port_read_strobe(hr), .i_port_write_strobe(hw), .i_port_chip_select_one(hc),
    .o_port_read_strobe(), .o_port_write_strobe(ws), .o_port_chip_select_one(cs1o),
    .o_port_chip_select_two(cs2o), .o_port_ctrl_oe(coe), .o_addr_latch_low(), .o_addr_latch_high(alh));
  // ==========
  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare one value and count the outcome.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One master cycle; busy stays high for one cycle less than the whole cycle.
  task automatic cyc(input logic [1:0] m, b, e, input logic [3:0] w, input logic r, input int t);
    mux = m; wb = b; wm = w; we = e;
    txd = txd + 16'h0101;
    if (r) rd = 1'b1;
    else txv = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    txv = 1'b0;
    n = 0;
    for (int i = 0; i < 60 && !(n > 0 && busy === 1'b0); i++) begin
      if (busy === 1'b1) n++;
      if (m == 2'h2 && doe === 1'b1) chk(pd[15:8], 16'h0000);
      // Both selects are enabled and addressed, so they stand from the first pin cycle on.
      if (n > 1 && busy === 1'b1) chk({cs1o, cs2o}, 16'h0003);
      // The top two address bits act as selects and must go out as zero.
      if (alh === 1'b1) chk(m == 2'h2 ? pd[7:6] : pd[15:14], 16'h0000);
      @(negedge clk);
    end
    if (busy !== 1'b0) begin
      miscompares++;
      tally_and_finish;
    end
    chk(n[15:0], t[15:0] - 16'h0001);
    @(negedge clk);
    // Pins lag the sequencer, so the hold cycle of a write shows here: strobe off, bus still driven.
    if (!r) chk({ws, doe}, 16'h0001);
    if (!r) chk(pd, m == 2'h2 ? {8'h00, txd[7:0]} : txd);
  endtask
  // ==========
  // Main sequence.
  initial begin
    nrst = 1'b0; en = 1'b0; rd = 1'b0; txv = 1'b0; irqc = 1'b0; ovc = 1'b0; pol = 1'b1;
    mode = 2'h1; mux = 2'h3; wb = 2'h0; we = 2'h0; wm = 4'h0; txd = 16'h1E2D;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    en = 1'b1;
    @(negedge clk);
    cyc(2'h2, 2'h3, 2'h3, 4'h0, 1'b0, 9);
    cyc(2'h2, 2'h1, 2'h1, 4'h2, 1'b0, 15);
    cyc(2'h3, 2'h3, 2'h3, 4'h0, 1'b1, 5);
    cyc(2'h3, 2'h1, 2'h1, 4'h2, 1'b1, 10);
    cyc(2'h3, 2'h0, 2'h0, 4'h0, 1'b0, 6);
    cyc(2'h3, 2'h1, 2'h1, 4'h2, 1'b0, 11);
    for (int p = 0; p < 2; p++) begin
      en = 1'b0;
      mode = 2'h0;
      pol = p[0];
      @(negedge clk);
      en = 1'b1; irqc = 1'b1; ovc = 1'b1; rd = 1'b1;
      @(negedge clk);
      irqc = 1'b0; ovc = 1'b0; rd = 1'b0;
      chk(coe, 1'b0);
      host.put(8'h5A + 8'(p));
      repeat (2) @(negedge clk);
      chk(full, 1'b0);
      @(negedge clk);
      chk(full, 1'b1);
      chk(irq, 1'b1);
      chk(rx[7:0], 8'h5A + 8'(p));
      host.rel;
      host.put(8'hC3);
      repeat (4) @(negedge clk);
      host.rel;
      chk(ovf, 1'b1);
      chk(rx[7:0], 8'h5A + 8'(p));
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk(full, 1'b0);
    end
    tally_and_finish;
  end
endmodule
